//--- src/aurw_pkg.sv
// package: register map, field positions and reset values of the serial receiver
package aurw_pkg;

  // register offsets (byte-wide registers on a plain port)
  localparam logic [3:0] OFS_RX_STATUS_CTRL = 4'h0;
  localparam logic [3:0] OFS_RX_DATA        = 4'h1;
  localparam logic [3:0] OFS_TX_STATUS_CTRL = 4'h2;
  localparam logic [3:0] OFS_BAUD_LINE_CTRL = 4'h3;
  localparam logic [3:0] OFS_BAUD_DIV_HIGH  = 4'h4;
  localparam logic [3:0] OFS_BAUD_DIV_LOW   = 4'h5;
  localparam logic [3:0] OFS_PERIPH_FLAGS   = 4'h6;
  localparam logic [3:0] OFS_PERIPH_ENABLES = 4'h7;
  localparam logic [3:0] OFS_PERIPH_PRIO    = 4'h8;

  // receive_status_control fields
  localparam int RSC_PORT_EN   = 7;
  localparam int RSC_NINE_BIT  = 6;
  localparam int RSC_CONT_RX   = 4;
  localparam int RSC_ADDR_DET  = 3;
  localparam int RSC_FRAME_ERR = 2;
  localparam int RSC_OVERRUN   = 1;
  localparam int RSC_NINTH_BIT = 0;
  // transmit_status_control fields
  localparam int TSC_SYNC_MODE = 4;
  localparam int TSC_HIGH_SPD  = 2;
  // baud_and_line_control fields
  localparam int BLC_RX_IDLE   = 6;
  localparam int BLC_RX_INVERT = 5;
  localparam int BLC_TX_INVERT = 4;
  localparam int BLC_SIXTEEN   = 3;
  localparam int BLC_WAKEUP    = 1;
  // peripheral flag / enable / priority field
  localparam int PF_RX_DONE    = 5;

  // reset values
  localparam logic [7:0] RST_RX_STATUS_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_STATUS_CTRL = 8'h02;
  localparam logic [7:0] RST_BAUD_LINE_CTRL = 8'h40;
  localparam logic [7:0] RST_BYTE           = 8'h00;
  localparam logic [7:0] RST_LINE_IDLE      = 8'h01;

  // timing counts
  localparam int OVERSAMPLE    = 16;
  localparam int MID_SAMPLE    = 7;
  localparam int SHORT_PRESCALE = 4;

  typedef enum logic [1:0] {
    AURW_IDLE  = 2'b00,
    AURW_START = 2'b01,
    AURW_DATA  = 2'b11,
    AURW_STOP  = 2'b10
  } aurw_state_e;

  typedef struct packed {
    logic       nine;
    logic [8:0] data;
    logic       stop_ok;
  } aurw_char_s;

endpackage

//--- src/aurw_baud_gen.sv
// baud rate generator: one-cycle tick at sixteen times the bit rate
`timescale 1ns/1ps
`default_nettype none
module aurw_baud_gen
  import aurw_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             run_i,
  input  wire logic             high_speed_i,
  input  wire logic             sixteen_i,
  input  wire logic [DIV_W-1:0] divisor_i,
  output logic                  tick_o
);
  // -----------------------------------------------------------------
  // divider chain
  // -----------------------------------------------------------------
  logic [DIV_W-1:0] count;
  logic [1:0]       pre;
  logic             short_path;
  logic [DIV_W-1:0] eff_div;
  logic             pre_done;
  logic             cnt_done;

  // (RULE22) x16 when either speed bit is set, else x64 via prescale of four
  assign short_path = high_speed_i | sixteen_i;
  assign eff_div    = sixteen_i ? divisor_i : {{(DIV_W-8){1'b0}}, divisor_i[7:0]};
  assign cnt_done   = (count == '0);
  assign pre_done   = short_path | (pre == 2'(SHORT_PRESCALE - 1));
  assign tick_o     = run_i & cnt_done & pre_done;

  // (RULE12) counter and prescaler held at zero whenever run_i is low
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count <= '0;
      pre   <= 2'h0;
    end else if (!run_i) begin
      count <= '0;
      pre   <= 2'h0;
    end else if (cnt_done) begin
      count <= eff_div;
      pre   <= pre_done ? 2'h0 : pre + 2'h1;
    end else begin
      count <= count - DIV_W'(1);
    end
  end
endmodule
`default_nettype wire

//--- src/aurw_shifter.sv
// receive shifter: start, data and stop sampling at sixteen ticks per bit
`timescale 1ns/1ps
`default_nettype none
module aurw_shifter
  import aurw_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic enable_i,
  input  wire logic tick_i,
  input  wire logic line_i,
  input  wire logic nine_i,
  output logic      busy_o,
  output logic      done_o,
  output aurw_pkg::aurw_char_s char_o
);
  // -----------------------------------------------------------------
  // bit sampler
  // -----------------------------------------------------------------
  aurw_state_e state;
  logic [3:0]  phase;
  logic [3:0]  bit_cnt;
  logic [8:0]  shreg;
  logic        mid;
  logic        last_bit;

  assign mid      = tick_i & (phase == 4'(MID_SAMPLE));
  // (RULE4) nine-bit character length
  assign last_bit = bit_cnt == (nine_i ? 4'h8 : 4'h7);
  assign busy_o   = state != AURW_IDLE;

  // (RULE1) x16 phase counter; shifter moves once per bit at mid sample
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state   <= AURW_IDLE;
      phase   <= 4'h0;
      bit_cnt <= 4'h0;
      shreg   <= 9'h000;
      done_o  <= 1'b0;
      char_o  <= '0;
    end else begin
      done_o <= 1'b0;
      if (!enable_i) begin
        state <= AURW_IDLE;
      end else if (tick_i) begin
        phase <= phase + 4'h1;
        unique case (state)
          AURW_IDLE: begin
            phase <= 4'h0;
            if (!line_i) begin
              state <= AURW_START;
              phase <= 4'h1;
            end
          end
          AURW_START: begin
            if (mid) begin
              state   <= line_i ? AURW_IDLE : AURW_DATA;
              bit_cnt <= 4'h0;
            end
          end
          // (RULE21) lsb first, eight or nine data bits
          AURW_DATA: begin
            if (mid) begin
              shreg   <= nine_i ? {line_i, shreg[8:1]} : {1'b0, line_i, shreg[7:1]};
              bit_cnt <= bit_cnt + 4'h1;
              if (last_bit) begin
                state <= AURW_STOP;
              end
            end
          end
          AURW_STOP: begin
            if (mid) begin
              state  <= AURW_IDLE;
              done_o <= 1'b1;
              char_o <= '{nine: nine_i, data: shreg, stop_ok: line_i};
            end
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- src/aurw_top.sv
// top of the asynchronous serial receiver with address detect and wake-up
//
// Notes on behaviour
// (RULE1) bits are recovered with a x16 sampler; the shifter moves once per bit
// (RULE2) receive polarity bit inverts the line before recovery
// (RULE3) asynchronous operation needs sync bit clear and port enable set
// (RULE4) nine-bit select receives nine data bits per character
// (RULE5) characters are received only while continuous receive is enabled
// (RULE6) a finished character sets the done flag; interrupt when enabled
// (RULE7) ninth bit, framing and overrun flags readable in receive status
// (RULE8) reading the data register returns the received eight-bit character
// (RULE9) clearing continuous receive clears latched receive errors
// (RULE10) nine-bit mode plus address enable selects address detect
// (RULE11) with address detect off every character is loaded and flagged; one completing into a full buffer is dropped and sets overrun instead
// (RULE12) sleep stops the baud generator and normal reception
// (RULE13) wake-up enable disables reception and watches the line
// (RULE14) a falling edge on the line is the wake-up event
// (RULE15) after wake-up the done flag is set, also while asleep
// (RULE16) reading the data register clears the done condition
// (RULE17) a rising edge after wake-up clears wake-up enable; reception resumes
// (RULE18) wake-up detection works only in asynchronous mode
// (RULE19) the far end sends an all-zero first character for wake-up
// (RULE20) the far end leaves a long enough break and idle time after it
// (RULE21) framing: start bit, eight or nine data bits, stop bit, lsb first
// (RULE22) baud generator runs at x16 or x64 per the two speed bits
// (RULE23) receiver-idle status bit shows whether reception is in progress
// (RULE24) in address detect only ninth-bit-one characters are loaded
// (RULE25) stop bit low sets framing error; completion while full sets overrun
//
// The implementer's own choices: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module aurw_top
  import aurw_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic       CLK_SYS_I,
  input  wire logic       RST_B_I,
  input  wire logic       SLEEP_I,
  input  wire logic       RX_LINE_I,
  input  wire logic [3:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  output logic            RX_IRQ_O,
  output logic            WAKE_O
);
  // -----------------------------------------------------------------
  // registers and decode
  // -----------------------------------------------------------------
  logic [7:0] rx_ctrl;
  logic [7:0] tx_ctrl;
  logic [7:0] baud_ctrl;
  logic [7:0] div_high;
  logic [7:0] div_low;
  logic [7:0] p_enables;
  logic [7:0] p_prio;
  logic [7:0] p_flags_wr;
  logic [7:0] rx_buf;
  logic       buf_ninth;
  logic       buf_full;
  logic       frame_err;
  logic       overrun;
  logic       rx_done_flag;
  logic       wake_enable;
  logic       wake_seen;
  logic       line_q;

  wire wr_rsc  = WR_I & (ADDR_I == OFS_RX_STATUS_CTRL);
  wire wr_tsc  = WR_I & (ADDR_I == OFS_TX_STATUS_CTRL);
  wire wr_blc  = WR_I & (ADDR_I == OFS_BAUD_LINE_CTRL);
  wire wr_divh = WR_I & (ADDR_I == OFS_BAUD_DIV_HIGH);
  wire wr_divl = WR_I & (ADDR_I == OFS_BAUD_DIV_LOW);
  wire wr_pf   = WR_I & (ADDR_I == OFS_PERIPH_FLAGS);
  wire wr_pe   = WR_I & (ADDR_I == OFS_PERIPH_ENABLES);
  wire wr_pp   = WR_I & (ADDR_I == OFS_PERIPH_PRIO);
  wire rd_data = RD_I & (ADDR_I == OFS_RX_DATA);

  // -----------------------------------------------------------------
  // mode decode
  // -----------------------------------------------------------------
  wire port_en   = rx_ctrl[RSC_PORT_EN];
  wire nine_sel  = rx_ctrl[RSC_NINE_BIT];
  wire cont_rx   = rx_ctrl[RSC_CONT_RX];
  // (RULE3) asynchronous only with sync clear and port enabled
  wire async_on  = port_en & ~tx_ctrl[TSC_SYNC_MODE];
  // (RULE10) address detect needs nine-bit mode
  wire addr_mode = nine_sel & rx_ctrl[RSC_ADDR_DET];
  // (RULE2) polarity applied ahead of the sampler and edge detect
  wire line      = RX_LINE_I ^ baud_ctrl[BLC_RX_INVERT];
  // (RULE12) sleep gates the generator; (RULE13) wake-up parks reception
  wire run       = async_on & ~SLEEP_I & ~wake_enable;
  // (RULE5) shifter only enabled while continuous receive is set
  wire rx_enable = run & cont_rx;

  wire       tick;
  wire       busy;
  wire       char_done;
  aurw_char_s rx_char;

  aurw_baud_gen #(
    .DIV_W (DIV_W)
  ) u_baud (
    .clk_i        (CLK_SYS_I),
    .rst_b_i      (RST_B_I),
    .run_i        (run),
    .high_speed_i (tx_ctrl[TSC_HIGH_SPD]),
    .sixteen_i    (baud_ctrl[BLC_SIXTEEN]),
    .divisor_i    (DIV_W'({div_high, div_low})),
    .tick_o       (tick)
  );

  aurw_shifter u_shift (
    .clk_i    (CLK_SYS_I),
    .rst_b_i  (RST_B_I),
    .enable_i (rx_enable),
    .tick_i   (tick),
    .line_i   (line),
    .nine_i   (nine_sel),
    .busy_o   (busy),
    .done_o   (char_done),
    .char_o   (rx_char)
  );

  // -----------------------------------------------------------------
  // character acceptance
  // -----------------------------------------------------------------
  // (RULE24) ninth bit zero is dropped in address mode; (RULE11) else all kept
  wire accept    = char_done & (~addr_mode | rx_char.data[8]);
  // (RULE25) completion into a full buffer is an overrun and is not stored
  wire load      = accept & ~buf_full;
  wire ovr_event = accept & buf_full;
  // (RULE14) falling edge while wake-up armed, (RULE18) async mode only
  wire wake_fall = wake_enable & async_on & ~wake_seen & line_q & ~line;
  // (RULE17) rising edge after the event ends the break
  wire wake_rise = wake_enable & wake_seen & ~line_q & line;

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      line_q <= 1'b1;
    end else begin
      line_q <= line;
    end
  end

  // data buffer and error flags
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rx_buf    <= RST_BYTE;
      buf_ninth <= 1'b0;
      buf_full  <= 1'b0;
      frame_err <= 1'b0;
      overrun   <= 1'b0;
    end else begin
      if (load) begin
        rx_buf    <= rx_char.data[7:0];
        buf_ninth <= rx_char.data[8];
        // (RULE25) framing error reflects the stop bit of the held character
        frame_err <= ~rx_char.stop_ok;
      end
      // (RULE16) read empties the buffer; a new load in that cycle wins
      if (load) begin
        buf_full <= 1'b1;
      end else if (rd_data) begin
        buf_full <= 1'b0;
      end
      // (RULE25) overrun set wins; (RULE9) cleared by dropping continuous receive
      if (ovr_event) begin
        overrun <= 1'b1;
      end else if (!cont_rx) begin
        overrun <= 1'b0;
      end
      if (!cont_rx && !load) begin
        frame_err <= 1'b0;
      end
    end
  end

  // done flag and wake-up control
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rx_done_flag <= 1'b0;
      wake_enable  <= 1'b0;
      wake_seen    <= 1'b0;
    end else begin
      // (RULE6) (RULE15) set wins over the read clear
      if (load || wake_fall) begin
        rx_done_flag <= 1'b1;
      end else if (rd_data) begin
        rx_done_flag <= 1'b0;
      end
      if (wake_fall) begin
        wake_seen <= 1'b1;
      end else if (wake_rise || !wake_enable) begin
        wake_seen <= 1'b0;
      end
      // (RULE17) hardware clear beats a software write in the same cycle
      if (wake_rise) begin
        wake_enable <= 1'b0;
      end else if (wr_blc) begin
        wake_enable <= WDATA_I[BLC_WAKEUP];
      end
    end
  end

  // software registers
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rx_ctrl    <= RST_RX_STATUS_CTRL;
      tx_ctrl    <= RST_TX_STATUS_CTRL;
      baud_ctrl  <= RST_BAUD_LINE_CTRL;
      div_high   <= RST_BYTE;
      div_low    <= RST_BYTE;
      p_enables  <= RST_BYTE;
      p_prio     <= RST_BYTE;
      p_flags_wr <= RST_BYTE;
    end else begin
      if (wr_rsc) rx_ctrl <= WDATA_I;
      if (wr_tsc) tx_ctrl <= WDATA_I;
      if (wr_blc) baud_ctrl <= WDATA_I;
      if (wr_divh) div_high <= WDATA_I;
      if (wr_divl) div_low <= WDATA_I;
      if (wr_pe) p_enables <= WDATA_I;
      if (wr_pp) p_prio <= WDATA_I;
      if (wr_pf) p_flags_wr <= WDATA_I;
    end
  end

  // -----------------------------------------------------------------
  // read path
  // -----------------------------------------------------------------
  // (RULE7) status byte carries ninth bit and the two error flags
  wire [7:0] rd_rsc = {rx_ctrl[7:3], frame_err, overrun, buf_ninth};
  // (RULE23) idle bit reads one while no character is in progress
  wire [7:0] rd_blc = {1'b0, ~busy, baud_ctrl[5:3], 1'b0, wake_enable, 1'b0};
  wire [7:0] rd_pf  = {p_flags_wr[7:6], rx_done_flag, p_flags_wr[4:0]};
  wire [7:0] rd_tsc = {tx_ctrl[7:2], 1'b1, tx_ctrl[0]};

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = RST_BYTE;
    unique case (ADDR_I)
      OFS_RX_STATUS_CTRL: next_rdata = rd_rsc;
      // (RULE8) data read returns the held character
      OFS_RX_DATA:        next_rdata = rx_buf;
      OFS_TX_STATUS_CTRL: next_rdata = rd_tsc;
      OFS_BAUD_LINE_CTRL: next_rdata = rd_blc;
      OFS_BAUD_DIV_HIGH:  next_rdata = div_high;
      OFS_BAUD_DIV_LOW:   next_rdata = div_low;
      OFS_PERIPH_FLAGS:   next_rdata = rd_pf;
      OFS_PERIPH_ENABLES: next_rdata = p_enables;
      OFS_PERIPH_PRIO:    next_rdata = p_prio;
      default:            next_rdata = RST_BYTE;
    endcase
  end

  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= RST_BYTE;
    end else begin
      RDATA_O <= RD_I ? next_rdata : RST_BYTE;
    end
  end

  // (RULE6) request follows the flag gated by the enable
  assign RX_IRQ_O = rx_done_flag & p_enables[PF_RX_DONE];
  // asynchronous wake path for a sleeping core, level from registers
  assign WAKE_O   = wake_seen;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_flag_on_load: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE6
    load |=> rx_done_flag) else $error("done flag not set after load");
  a_read_clears: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE16
    rd_data && !load && !wake_fall |=> !rx_done_flag) else $error("read did not clear flag");
  a_wake_clears: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE17
    wake_rise |=> !wake_enable) else $error("wake enable not cleared");
  a_wake_flags: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE15
    wake_fall |=> rx_done_flag && wake_seen) else $error("wake event not flagged");
  a_no_rx_wake: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE13
    wake_enable |-> !tick) else $error("baud tick while wake-up armed");
  a_sleep_halt: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE12
    SLEEP_I |-> !tick) else $error("baud tick in sleep");
  a_overrun_set: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE25
    ovr_event |=> overrun && $stable(rx_buf)) else $error("overrun not flagged");
  a_err_clear: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE9
    !cont_rx && !load |=> !overrun && !frame_err) else $error("errors not cleared");
  a_addr_drop: assert property (@(posedge CLK_SYS_I) disable iff (!RST_B_I) // RULE24
    char_done && addr_mode && !rx_char.data[8] |=> $stable(rx_buf)) else $error("address drop");
endmodule
`default_nettype wire

//--- verification/aurw_remote_tx.sv
// remote asynchronous serial transmitter model driving the receive line
`timescale 1ns/1ps
`default_nettype none
module aurw_remote_tx (
  input  wire logic clk_i,
  input  wire logic inv_i,
  output logic      line_o
);
  logic raw = 1'b1;

  // the line rests at the mark level between frames, high unless inv_i inverts it
  assign line_o = raw ^ inv_i;

  task automatic bit_out(input logic b, input int n);
    raw <= b;
    repeat (n) @(posedge clk_i);
  endtask

  // start bit, data lsb first, stop bit
  task automatic send(input logic [8:0] d, input int nbits, input logic stop, input int bclk);
    int i;
    @(posedge clk_i);
    bit_out(1'b0, bclk);
    for (i = 0; i < nbits; i++)
      bit_out(d[i], bclk);
    bit_out(stop, bclk);
    bit_out(1'b1, 2 * bclk);
  endtask

  // all-zero break, then a long idle
  task automatic hold_low(input int n);
    @(posedge clk_i);
    bit_out(1'b0, n);
    bit_out(1'b1, 32);
  endtask
endmodule
`default_nettype wire

//--- verification/aurw_top_test.sv
// testbench of the serial receiver: register scenarios and remote frames
`timescale 1ns/1ps
`default_nettype none
module aurw_top_test;
  import aurw_pkg::*;
  logic       clk   = 1'b0;
  logic       rst_b = 1'b0;
  logic       sleep = 1'b0;
  logic       inv   = 1'b0;
  logic       line;
  logic [3:0] addr  = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr    = 1'b0;
  logic       rd    = 1'b0;
  logic [7:0] rdata;
  logic       irq;
  logic       wake;
  int         n_fail     = 0;
  int         num_checks = 0;

  always #20 clk = ~clk;

  aurw_top dut (
    .CLK_SYS_I(clk), .RST_B_I(rst_b), .SLEEP_I(sleep), .RX_LINE_I(line),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
    .RDATA_O(rdata), .RX_IRQ_O(irq), .WAKE_O(wake)
  );
  aurw_remote_tx tx (.clk_i(clk), .inv_i(inv), .line_o(line));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic expect_reg(input string what, input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(what, rdata, exp);
  endtask

  task automatic pins(input logic exp_irq, input logic exp_wake);
    check("irq", {7'h00, irq}, {7'h00, exp_irq});
    check("wake", {7'h00, wake}, {7'h00, exp_wake});
  endtask

  // one frame in, then status, flags, data and a cleared request
  task automatic rx_expect(input logic [8:0] d, input int nb, input logic stop,
                           input int bclk, input logic [7:0] st, input logic [7:0] dat);
    tx.send(d, nb, stop, bclk);
    pins(1'b1, 1'b0);
    expect_reg("status", OFS_RX_STATUS_CTRL, st);
    expect_reg("flags", OFS_PERIPH_FLAGS, 8'h20);
    expect_reg("data", OFS_RX_DATA, dat);
    pins(1'b0, 1'b0);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset;
    pins(1'b0, 1'b0);
    expect_reg("rx ctrl", OFS_RX_STATUS_CTRL, RST_RX_STATUS_CTRL);
    expect_reg("tx ctrl", OFS_TX_STATUS_CTRL, RST_TX_STATUS_CTRL);
    expect_reg("baud ctrl", OFS_BAUD_LINE_CTRL, RST_BAUD_LINE_CTRL);
    expect_reg("div low", OFS_BAUD_DIV_LOW, RST_BYTE);
    wr_reg(OFS_BAUD_DIV_HIGH, 8'hA5);
    expect_reg("div high", OFS_BAUD_DIV_HIGH, 8'hA5);
    @(posedge clk);
    #1;
    check("idle bus", rdata, 8'h00);
    wr_reg(4'h9, 8'hFF);
    expect_reg("unmapped", 4'h9, 8'h00);
    wr_reg(OFS_BAUD_DIV_HIGH, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_basic;
    // one tick per clock keeps a bit at sixteen clocks
    wr_reg(OFS_TX_STATUS_CTRL, 8'h04);
    wr_reg(OFS_PERIPH_ENABLES, 8'h20);
    wr_reg(OFS_RX_STATUS_CTRL, 8'h90);
    fork
      tx.send(9'h0A5, 8, 1'b1, 16);
      begin
        repeat (40) @(posedge clk);
        expect_reg("busy", OFS_BAUD_LINE_CTRL, 8'h00);
      end
    join
    pins(1'b1, 1'b0);
    expect_reg("status", OFS_RX_STATUS_CTRL, 8'h90);
    expect_reg("data", OFS_RX_DATA, 8'hA5);
    pins(1'b0, 1'b0);
    expect_reg("idle", OFS_BAUD_LINE_CTRL, 8'h40);
    rx_expect(9'h0C3, 8, 1'b1, 16, 8'h90, 8'hC3);
    $display("test basic done");
  endtask

  task automatic t_nine;
    wr_reg(OFS_RX_STATUS_CTRL, 8'hD8);
    tx.send(9'h055, 9, 1'b1, 16);
    pins(1'b0, 1'b0);
    rx_expect(9'h12A, 9, 1'b1, 16, 8'hD9, 8'h2A);
    wr_reg(OFS_RX_STATUS_CTRL, 8'hD0);
    rx_expect(9'h033, 9, 1'b1, 16, 8'hD0, 8'h33);
    $display("test nine bit done");
  endtask

  task automatic t_errors;
    wr_reg(OFS_RX_STATUS_CTRL, 8'h90);
    tx.send(9'h011, 8, 1'b1, 16);
    tx.send(9'h022, 8, 1'b1, 16);
    expect_reg("overrun", OFS_RX_STATUS_CTRL, 8'h92);
    expect_reg("kept", OFS_RX_DATA, 8'h11);
    wr_reg(OFS_RX_STATUS_CTRL, 8'h80);
    expect_reg("cleared", OFS_RX_STATUS_CTRL, 8'h80);
    wr_reg(OFS_RX_STATUS_CTRL, 8'h90);
    rx_expect(9'h000, 8, 1'b0, 16, 8'h94, 8'h00);
    // the later half of the low stop bit reads as a new start; idle ones follow
    repeat (120) @(posedge clk);
    expect_reg("after break", OFS_RX_DATA, 8'hFF);
    rx_expect(9'h05A, 8, 1'b1, 16, 8'h90, 8'h5A);
    $display("test errors done");
  endtask

  task automatic t_refused;
    wr_reg(OFS_RX_STATUS_CTRL, 8'h80);
    tx.send(9'h077, 8, 1'b1, 16);
    pins(1'b0, 1'b0);
    wr_reg(OFS_RX_STATUS_CTRL, 8'h90);
    @(posedge clk);
    sleep <= 1'b1;
    tx.send(9'h066, 8, 1'b1, 16);
    pins(1'b0, 1'b0);
    sleep <= 1'b0;
    wr_reg(OFS_TX_STATUS_CTRL, 8'h14);
    tx.send(9'h055, 8, 1'b1, 16);
    pins(1'b0, 1'b0);
    wr_reg(OFS_TX_STATUS_CTRL, 8'h00);
    // both speed bits clear: sixty-four clocks per bit
    rx_expect(9'h096, 8, 1'b1, 64, 8'h90, 8'h96);
    wr_reg(OFS_TX_STATUS_CTRL, 8'h04);
    // sixteen-bit divisor of one: a tick every second clock
    wr_reg(OFS_BAUD_DIV_LOW, 8'h01);
    wr_reg(OFS_BAUD_LINE_CTRL, 8'h08);
    rx_expect(9'h0E7, 8, 1'b1, 32, 8'h90, 8'hE7);
    wr_reg(OFS_BAUD_DIV_LOW, 8'h00);
    $display("test refused and slow done");
  endtask

  task automatic t_wake;
    wr_reg(OFS_BAUD_LINE_CTRL, 8'h02);
    expect_reg("wake set", OFS_BAUD_LINE_CTRL, 8'h42);
    fork
      tx.hold_low(208);
      begin
        repeat (40) @(posedge clk);
        #1;
        pins(1'b1, 1'b1);
      end
    join
    pins(1'b1, 1'b0);
    expect_reg("wake auto clear", OFS_BAUD_LINE_CTRL, 8'h40);
    expect_reg("dummy", OFS_RX_STATUS_CTRL, 8'h90);
    wr_reg(4'h9, 8'h00);
    expect_reg("flags", OFS_PERIPH_FLAGS, 8'h20);
    // wake-up loads nothing, so the last character still stands
    expect_reg("dummy data", OFS_RX_DATA, 8'hE7);
    pins(1'b0, 1'b0);
    rx_expect(9'h081, 8, 1'b1, 16, 8'h90, 8'h81);
    $display("test wake done");
  endtask

  task automatic t_invert;
    // reception is off while line and polarity change, so no false start
    wr_reg(OFS_RX_STATUS_CTRL, 8'h80);
    wr_reg(OFS_BAUD_LINE_CTRL, 8'h20);
    @(posedge clk);
    inv <= 1'b1;
    repeat (4) @(posedge clk);
    wr_reg(OFS_RX_STATUS_CTRL, 8'h90);
    rx_expect(9'h03C, 8, 1'b1, 16, 8'h90, 8'h3C);
    $display("test invert done");
  endtask

  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    t_reset;
    t_basic;
    t_nine;
    t_errors;
    t_refused;
    t_wake;
    t_invert;
    report_and_stop;
  end

  // the run needs about four and a half thousand cycles
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    report_and_stop;
  end
endmodule
`default_nettype wire
